// file: rtl/scr_cell_reg.sv
/*
 * scr_cell_reg: one read-to-invalidate result register.
 * Assumes load and read-clear strobes are synchronous to i_ref_clk.
 */
`timescale 1ns/1ps
module scr_cell_reg
   import scr_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_clk_en,
   input wire logic i_load,
   input wire logic [SCR_DW-1:0] i_load_val,
   input wire logic i_rd_clr,
   output logic [SCR_DW-1:0] o_val
);
   logic [SCR_DW-1:0] val_r;
   logic [SCR_DW-1:0] val_nxt;

   // a fresh result wins over a read clear in the same cycle, so a
   // result landing under a read is never lost
   always_comb begin
      val_nxt = val_r;
      if (i_load) begin
         val_nxt = i_load_val; // [R02] [R03]
      end else if (i_rd_clr) begin
         val_nxt = SCR_RESULT_INVALID; // [R04]
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         val_r <= SCR_RESULT_INVALID; // [R04]
      end else if (i_clk_en) begin
         val_r <= val_nxt;
      end
   end

   assign o_val = val_r;

   property p_load_takes;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en && i_load |=> o_val == $past(i_load_val);
   endproperty
   a_load_takes: assert property (p_load_takes) // [R02]
      else $error("result not loaded from engine");

   property p_read_clears;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en && i_rd_clr && !i_load |=> o_val == SCR_RESULT_INVALID;
   endproperty
   a_read_clears: assert property (p_read_clears) // [R04]
      else $error("read did not invalidate result");

   property p_hold;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (!i_clk_en || (!i_load && !i_rd_clr)) |=> $stable(o_val);
   endproperty
   a_hold: assert property (p_hold) // [R05]
      else $error("result changed without load or read");
endmodule : scr_cell_reg

// file: rtl/scr_pkg.sv
/*
 * scr_pkg: constants shared by the synchronous cell result register bank.
 * Assumes 16-bit registers at word addresses on the device register port.
 */
package scr_pkg;
   localparam int unsigned SCR_DW = 16;
   localparam int unsigned SCR_AW = 16;
   localparam int unsigned SCR_NCELL = 7;
   localparam int unsigned SCR_IDXW = 3;
   localparam int unsigned SCR_FIRST_CELL = 4;

   // word addresses on the register port
   localparam logic [15:0] SCR_ADDR_CYCLE_NUM = 16'h187f;
   localparam logic [15:0] SCR_ADDR_CELL4 = 16'h1884;
   localparam logic [15:0] SCR_ADDR_CELL5 = 16'h1885;
   localparam logic [15:0] SCR_ADDR_CELL6 = 16'h1886;
   localparam logic [15:0] SCR_ADDR_CELL7 = 16'h1887;
   localparam logic [15:0] SCR_ADDR_CELL8 = 16'h1888;
   localparam logic [15:0] SCR_ADDR_CELL9 = 16'h1889;
   localparam logic [15:0] SCR_ADDR_CELL10 = 16'h188a;

   // reset and special values
   localparam logic [15:0] SCR_RESULT_INVALID = 16'h8000;
   localparam logic [15:0] SCR_CYCLE_NUM_RST = 16'h0000;
   localparam logic [15:0] SCR_CYCLE_NUM_STEP = 16'h0001;
   localparam logic [15:0] SCR_RDATA_UNMAPPED = 16'h0000;
   localparam logic [15:0] SCR_RDATA_RST = 16'h0000;

   typedef enum logic [1:0] {
      SCR_SEL_NONE = 2'b00,
      SCR_SEL_CELL = 2'b01,
      SCR_SEL_CYCLE = 2'b10
   } scr_sel_t;
endpackage : scr_pkg

// file: rtl/scr_result_regs.sv
/*
 * scr_result_regs: synchronous cell result registers, cells 4 to 10,
 * plus the synchronous cycle number.
 * Assumes register port and engine strobes share i_ref_clk (20 MHz).
 */
// Function
// R01: one result register per cell 4..10 at word addresses 1884h..188Ah.
// R02: each register takes its cell's latest synchronous result, replacing old.
// R03: result is a 16-bit two's-complement value filling bits 15:0.
// R04: reset and every read leave 8000h until the next result.
// R05: host writes never change result registers.
// R06: cycle number at 187Fh counts synchronous cycles and wraps.
`timescale 1ns/1ps
module scr_result_regs
   import scr_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_clk_en,
   input wire logic [SCR_AW-1:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic i_reg_wr,
   input wire logic [SCR_DW-1:0] i_reg_wdata,
   output logic [SCR_DW-1:0] o_reg_rdata,
   output logic o_reg_ack,
   input wire logic i_sync_done,
   input wire logic [SCR_NCELL-1:0][SCR_DW-1:0] i_sync_volt,
   output logic [SCR_DW-1:0] o_sync_cycle_num
);
   scr_sel_t sel;
   logic [SCR_IDXW-1:0] cell_idx;
   logic [SCR_AW-1:0] cell_off;
   logic [SCR_NCELL-1:0] rd_clr;
   logic [SCR_NCELL-1:0][SCR_DW-1:0] cell_val;
   logic sync_load;
   logic rd_take;
   logic wr_take;

   logic [SCR_DW-1:0] cycle_num_r;
   logic [SCR_DW-1:0] cycle_num_nxt;
   logic [SCR_DW-1:0] rdata_r;
   logic [SCR_DW-1:0] rdata_nxt;
   logic ack_r;
   logic ack_nxt;

   // a read wins over a write in the same cycle; writes are only
   // acknowledged, since every register here is read-only
   assign rd_take = i_clk_en && i_reg_rd;
   assign wr_take = i_clk_en && i_reg_wr && !i_reg_rd; // [R05]
   assign sync_load = i_clk_en && i_sync_done;
   assign cell_off = i_reg_addr - SCR_ADDR_CELL4;

   // address decode
   always_comb begin
      sel = SCR_SEL_NONE;
      cell_idx = '0;
      if (i_reg_addr == SCR_ADDR_CYCLE_NUM) begin
         sel = SCR_SEL_CYCLE; // [R06]
      end else if (i_reg_addr >= SCR_ADDR_CELL4 &&
                   i_reg_addr <= SCR_ADDR_CELL10) begin
         sel = SCR_SEL_CELL; // [R01]
         cell_idx = cell_off[SCR_IDXW-1:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < SCR_NCELL; g++) begin : g_cell
         // one clear strobe per cell, only for the addressed one
         assign rd_clr[g] = rd_take && sel == SCR_SEL_CELL &&
                            cell_idx == SCR_IDXW'(g); // [R04]
         scr_cell_reg u_cell (
            .i_ref_clk(i_ref_clk),
            .i_arst_n(i_arst_n),
            .i_clk_en(i_clk_en),
            .i_load(sync_load), // [R02]
            .i_load_val(i_sync_volt[g]),
            .i_rd_clr(rd_clr[g]),
            .o_val(cell_val[g])
         );
      end
   endgenerate

   // cycle number, wraps naturally at its 16-bit limit
   always_comb begin
      cycle_num_nxt = cycle_num_r;
      if (i_sync_done) begin
         cycle_num_nxt = cycle_num_r + SCR_CYCLE_NUM_STEP; // [R06]
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cycle_num_r <= SCR_CYCLE_NUM_RST;
      end else if (i_clk_en) begin
         cycle_num_r <= cycle_num_nxt;
      end
   end

   // read data: the content before the clear is what the host sees
   always_comb begin
      rdata_nxt = rdata_r;
      ack_nxt = rd_take || wr_take;
      if (rd_take) begin
         case (sel)
            SCR_SEL_CELL: begin
               rdata_nxt = cell_val[cell_idx]; // [R01] [R03] [R04]
            end
            SCR_SEL_CYCLE: begin
               rdata_nxt = cycle_num_r; // [R06]
            end
            default: begin
               rdata_nxt = SCR_RDATA_UNMAPPED;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r <= SCR_RDATA_RST;
         ack_r <= 1'b0;
      end else if (i_clk_en) begin
         rdata_r <= rdata_nxt;
         ack_r <= ack_nxt;
      end
   end

   assign o_reg_rdata = rdata_r;
   assign o_reg_ack = ack_r;
   assign o_sync_cycle_num = cycle_num_r;

   property p_map_cell4;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en && i_reg_rd && i_reg_addr == SCR_ADDR_CELL4
      |=> o_reg_ack && o_reg_rdata == $past(cell_val[0]);
   endproperty
   a_map_cell4: assert property (p_map_cell4) // [R01]
      else $error("cell 4 address returned wrong data");

   property p_map_cell10;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en && i_reg_rd && i_reg_addr == SCR_ADDR_CELL10
      |=> o_reg_rdata == $past(cell_val[6]);
   endproperty
   a_map_cell10: assert property (p_map_cell10) // [R01]
      else $error("cell 10 address returned wrong data");

   property p_read_then_invalid;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en && i_reg_rd && i_reg_addr == SCR_ADDR_CELL7 && !i_sync_done
      |=> cell_val[3] == SCR_RESULT_INVALID;
   endproperty
   a_read_then_invalid: assert property (p_read_then_invalid) // [R04]
      else $error("cell 7 not invalid after read");

   property p_all_loaded;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en && i_sync_done |=> cell_val == $past(i_sync_volt);
   endproperty
   a_all_loaded: assert property (p_all_loaded) // [R02] [R03]
      else $error("bank not loaded with synchronous results");

   property p_write_ignored;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en && i_reg_wr && !i_reg_rd && !i_sync_done
      |=> $stable(cell_val) ##0 o_reg_ack;
   endproperty
   a_write_ignored: assert property (p_write_ignored) // [R05]
      else $error("host write altered a result register");

   property p_cycle_inc;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en && i_sync_done
      |=> o_sync_cycle_num == 16'($past(cycle_num_r) + SCR_CYCLE_NUM_STEP);
   endproperty
   a_cycle_inc: assert property (p_cycle_inc) // [R06]
      else $error("cycle number did not advance");

   property p_cycle_hold;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      !(i_clk_en && i_sync_done) |=> $stable(o_sync_cycle_num);
   endproperty
   a_cycle_hold: assert property (p_cycle_hold) // [R06]
      else $error("cycle number moved without a cycle");

   property p_unmapped;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en && i_reg_rd && sel == SCR_SEL_NONE
      |=> o_reg_ack && o_reg_rdata == SCR_RDATA_UNMAPPED;
   endproperty
   a_unmapped: assert property (p_unmapped) // [R01]
      else $error("unmapped read not answered with zero");

   property p_ack_pulse;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en |=> o_reg_ack == $past(i_reg_rd || i_reg_wr);
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) // [R04]
      else $error("register port ack not a one-cycle answer");

   // enable low must freeze the port as well as the bank
   property p_freeze;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      !i_clk_en |=> $stable(o_reg_rdata) && $stable(o_reg_ack) &&
                    $stable(cell_val);
   endproperty
   a_freeze: assert property (p_freeze) // [R05]
      else $error("state moved while clock enable low");

   property p_cycle_read_keeps;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en && i_reg_rd && sel == SCR_SEL_CYCLE && !i_sync_done
      |=> $stable(cell_val) && o_reg_rdata == $past(cycle_num_r);
   endproperty
   a_cycle_read_keeps: assert property (p_cycle_read_keeps) // [R06]
      else $error("cycle number read disturbed the bank");

   property p_clear_only_addressed;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_clk_en && i_reg_rd && i_reg_addr == SCR_ADDR_CELL4 && !i_sync_done
      |=> $stable(cell_val[SCR_NCELL-1:1]);
   endproperty
   a_clear_only_addressed: assert property (p_clear_only_addressed) // [R04]
      else $error("read of cell 4 cleared another cell");
endmodule : scr_result_regs

// file: testbench/scr_engine_model.sv
/*
 * scr_engine_model: stand-in measurement engine, ends one synchronous
 * cycle per i_fire with cell k showing i_base + k.
 * Assumes i_fire is a one-cycle pulse on i_ref_clk.
 */
`timescale 1ns/1ps
module scr_engine_model
   import scr_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_fire,
   input wire logic [SCR_DW-1:0] i_base,
   output logic o_sync_done,
   output logic [SCR_NCELL-1:0][SCR_DW-1:0] o_sync_volt
);
   // outside the done pulse the bus toggles, so stale data never matches
   always @(posedge i_ref_clk) begin
      o_sync_done <= i_fire;
      for (int k = 0; k < SCR_NCELL; k++) begin
         o_sync_volt[k] <= i_fire ? i_base + 16'(k) : ~o_sync_volt[k];
      end
   end
endmodule : scr_engine_model

// file: testbench/scr_result_regs_tb_top.sv
/*
 * scr_result_regs_tb_top: register-port tests of the result bank.
 * Assumes the strobe protocol and one-cycle ack of the register port.
 */
`timescale 1ns/1ps
module scr_result_regs_tb_top import scr_pkg::*; ;
   logic clk, rst_n, rd, wr, fire, ack, done, ce;
   logic [15:0] addr, wdata, base, rdata, cnum, v;
   logic [SCR_NCELL-1:0][SCR_DW-1:0] volt;
   int miscompares, comparisons;

   scr_result_regs u_dut (.i_ref_clk(clk), .i_arst_n(rst_n),
      .i_clk_en(ce), .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
      .i_sync_done(done), .i_sync_volt(volt), .o_sync_cycle_num(cnum));
   scr_engine_model u_eng (.i_ref_clk(clk), .i_fire(fire), .i_base(base),
      .o_sync_done(done), .o_sync_volt(volt));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // one strobe pulse, then a bounded wait for the ack
   task automatic acc(input logic is_rd, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] q);
      int n;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      rd <= is_rd;
      wr <= ~is_rd;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      #1;
      n = 0;
      while (ack !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (ack !== 1'b1) begin
         miscompares++;
         end_of_test();
      end
      q = rdata;
   endtask : acc

   task automatic sync(input logic [15:0] b);
      @(posedge clk);
      fire <= 1'b1;
      base <= b;
      @(posedge clk);
      fire <= 1'b0;
      @(posedge clk);
      #1;
   endtask : sync

   initial begin
      miscompares = 0;
      comparisons = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      fire = 1'b0;
      addr = 16'h0000;
      wdata = 16'h0000;
      base = 16'h0000;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      acc(1'b1, SCR_ADDR_CYCLE_NUM, 16'h0000, v);
      check(v, 16'h0000);
      for (int k = 0; k < 7; k++) begin
         acc(1'b1, SCR_ADDR_CELL4 + 16'(k), 16'h0000, v);
         check(v, 16'h8000);
      end
      $display("test reset done");
      // negative results cover the signed full-width encoding
      sync(16'hfff0);
      check(cnum, 16'h0001);
      acc(1'b1, SCR_ADDR_CYCLE_NUM, 16'h0000, v);
      check(v, 16'h0001);
      for (int k = 0; k < 7; k++) begin
         acc(1'b1, 16'h1884 + 16'(k), 16'h0000, v);
         check(v, 16'hfff0 + 16'(k));
         acc(1'b1, 16'h1884 + 16'(k), 16'h0000, v);
         check(v, 16'h8000);
      end
      $display("test load and read-clear done");
      sync(16'h1000);
      sync(16'h0123);
      check(cnum, 16'h0003);
      for (int k = 0; k < 7; k++) begin
         acc(1'b0, 16'h1884 + 16'(k), 16'h5a5a, v);
      end
      for (int k = 0; k < 7; k++) begin
         acc(1'b1, 16'h1884 + 16'(k), 16'h0000, v);
         check(v, 16'h0123 + 16'(k));
      end
      $display("test overwrite and write-ignore done");
      acc(1'b1, 16'h1883, 16'h0000, v);
      check(v, 16'h0000);
      acc(1'b1, 16'h188b, 16'h0000, v);
      check(v, 16'h0000);
      $display("test address edges done");
      // a frozen bank must ignore both the engine and the host
      sync(16'h0200);
      check(cnum, 16'h0004);
      @(posedge clk);
      ce <= 1'b0;
      sync(16'h0777);
      @(posedge clk);
      addr <= SCR_ADDR_CELL4;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check({15'h0000, ack}, 16'h0000);
      check(cnum, 16'h0004);
      @(posedge clk);
      ce <= 1'b1;
      acc(1'b1, SCR_ADDR_CELL4, 16'h0000, v);
      check(v, 16'h0200);
      $display("test clock enable freeze done");
      // a mid-run reset drops loaded results back to invalid
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      acc(1'b1, SCR_ADDR_CELL5, 16'h0000, v);
      check(v, 16'h8000);
      check(cnum, 16'h0000);
      $display("test mid-run reset done");
      end_of_test();
   end
endmodule : scr_result_regs_tb_top
